// [shared/smoc_pkg.sv]
// Shared constants and carrier types for the speed monitor output control.
// Assumes one 125 MHz device clock and configuration held steady by the host logic.
package smoc_pkg;
    localparam int          CLK_MHZ       = 125;
    localparam int          TICK_MS_US    = 1000;
    localparam int          TICK_MS_CYC   = TICK_MS_US * CLK_MHZ;
    localparam int          FILT_T99_SLOW = 420000;
    localparam int          FILT_T99_AVG  = 47000;
    localparam int          FILT_T99_FAST = 9000;
    // 99 % takes 4.6 time constants, one constant is 16 filter steps
    localparam int          FILT_STEPS99  = 74;
    localparam int          FILT_SHIFT    = 4;
    localparam int          SPEED_W       = 16;
    localparam int          N_SETS        = 16;
    localparam int          N_FN          = 9;
    localparam int          N_OUT         = 8;
    localparam logic [15:0] ANA_FULL_UA   = 16'h4e20;
    localparam logic [15:0] ANA_CEIL_UA   = 16'h55f0;
    localparam logic [15:0] ANA_LIVE_UA   = 16'h0fa0;
    localparam logic [3:0]  BASE_SET      = 4'h0;
    localparam logic [3:0]  SRC_ERR       = 4'he;
    localparam logic [3:0]  SRC_RANGE0    = 4'ha;
    localparam int          ANA_OUT       = 5;

    typedef enum logic [1:0] {
        FN_OFF   = 2'b00,
        FN_ON    = 2'b01,
        FN_STILL = 2'b10,
        FN_SPEED = 2'b11
    } smoc_fn_t;

    typedef enum logic [1:0] {
        ST_AUTO = 2'b00,
        ST_RISE = 2'b01,
        ST_FALL = 2'b10
    } smoc_start_t;

    typedef enum logic [2:0] {
        DL_NONE  = 3'b000,
        DL_ON_RT = 3'b001,
        DL_OFFRT = 3'b010,
        DL_BOTH  = 3'b011,
        DL_OFFNR = 3'b100
    } smoc_dly_t;

    typedef enum logic [1:0] {
        FS_SLOW = 2'b00,
        FS_AVG  = 2'b01,
        FS_FAST = 2'b10
    } smoc_filt_t;

    typedef struct packed {
        logic [3:0]  src;
        smoc_start_t start;
        smoc_dly_t   dly;
        logic [9:0]  dly_ms;
        logic        sync;
        logic        invert;
    } smoc_out_cfg_t;

    typedef struct packed {
        logic            en;
        smoc_fn_t        kind;
        logic [3:0]      set;
        logic [3:0]      fn;
        logic [15:0]     limit;
    } smoc_fn_wr_t;
endpackage

// [core/smoc_core.sv]
// Output control of a safety speed monitor: filter, switch functions, delays, start, outputs.
// Assumes speed_in is a same-clock measured frequency; start, set select, feedback and fault inputs are pins.
`timescale 1ns/10ps
// Operation
// - Filter speed before monitors when enabled
// - Three filter strengths: 420, 47, 9 ms
// - Automatic start turns on when condition holds
// - Rising start edge after condition turns on
// - Falling start edge after condition turns on
// - Speed functions and ranges ignore encoder during configurable start-up delay
// - Group member waits until whole group off
// - Group members keep own conditions, independent
// - Two relays, four semiconductor, two expansion outputs
// - Fault drops root relay, both relays off
// - Semiconductor outputs may run inverted
// - Per-output delay on on, off or both
// - On-delay retriggers on each rising edge
// - Off-delay cancelled by rising edge, stays on
// - Both-edge delay restarts on any edge
// - Non-retriggerable off-delay ignores rising edges
// - Refuse start while feedback loop is open
// - Fourth semiconductor output can be analogue
// - Current proportional, full at fmax, capped
// - Sixteen sets of nine functions, select pins
// - Output takes function or range; sharing allowed
// - Single-set mode uses base set only
module smoc_core
    import smoc_pkg::*;
#(
    parameter int TICK_CYC      = TICK_MS_CYC,
    parameter int FILT_CYC_SLOW = FILT_T99_SLOW * CLK_MHZ / FILT_STEPS99,
    parameter int FILT_CYC_AVG  = FILT_T99_AVG * CLK_MHZ / FILT_STEPS99,
    parameter int FILT_CYC_FAST = FILT_T99_FAST * CLK_MHZ / FILT_STEPS99
) (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire logic [smoc_pkg::SPEED_W-1:0]       speed_in,
    input  wire logic                               filter_en,
    input  wire smoc_pkg::smoc_filt_t               filter_sel,
    input  wire logic [15:0]                        startup_ms,
    input  wire logic                               single_set_mode,
    input  wire smoc_pkg::smoc_fn_wr_t              fn_wr,
    input  wire smoc_pkg::smoc_out_cfg_t [7:0]      out_cfg,
    input  wire logic                               start_terminal,
    input  wire logic [3:0]                         set_select,
    input  wire logic [7:0]                         fb_closed,
    input  wire logic                               fault_in,
    input  wire logic                               ana_en,
    input  wire logic                               ana_live_zero,
    input  wire logic [smoc_pkg::SPEED_W-1:0]       ana_fmax,
    output logic [1:0]                              relay_q,
    output logic                                    root_relay_q,
    output logic [3:0]                              semi_q,
    output logic [1:0]                              ext_q,
    output logic [15:0]                             analogue_ua_q,
    output logic [3:0]                              act_set_q
);
    import smoc_pkg::*;

    localparam int NP = 14;

    // Pin synchroniser, three stages; a change counts once stages 2 and 3 agree
    logic [NP-1:0] s1_q, s2_q, s3_q, pin_q;
    logic          start_prev_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            pin_q <= '0;
        end else begin
            s1_q  <= {fault_in, fb_closed, set_select, start_terminal};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) start_prev_q <= 1'b0;
        else        start_prev_q <= pin_q[0];
    end
    logic start_rise, start_fall;
    assign start_rise = pin_q[0] & ~start_prev_q;
    assign start_fall = ~pin_q[0] & start_prev_q;

    // Millisecond tick
    logic [$clog2(TICK_CYC)-1:0] tick_cnt_q;
    logic                        tick_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= (tick_cnt_q == $clog2(TICK_CYC)'(TICK_CYC - 2));
            tick_cnt_q <= tick_q ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Start-up delay: speed functions and ranges ignore encoder until it expires
    logic [15:0] up_cnt_q;
    logic        enc_ok_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt_q <= '0;
            enc_ok_q <= 1'b0;
        end else if (!enc_ok_q) begin
            if (up_cnt_q >= startup_ms) enc_ok_q <= 1'b1;
            else if (tick_q)            up_cnt_q <= up_cnt_q + 1'b1;
        end
    end

    // First-order filter, strength set by step period
    logic [19:0] filt_cnt_q, filt_per;
    logic [SPEED_W+FILT_SHIFT-1:0] filt_q;
    always_comb begin
        unique case (filter_sel)
            FS_AVG:  filt_per = 20'(FILT_CYC_AVG);
            FS_FAST: filt_per = 20'(FILT_CYC_FAST);
            default: filt_per = 20'(FILT_CYC_SLOW);
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_cnt_q <= '0;
            filt_q     <= '0;
        end else if (filt_cnt_q >= filt_per - 20'h00001) begin
            filt_cnt_q <= '0;
            filt_q <= filt_q + SPEED_W'(speed_in) - (filt_q >> FILT_SHIFT);
        end else begin
            filt_cnt_q <= filt_cnt_q + 20'h00001;
        end
    end
    logic [SPEED_W-1:0] mspd;
    assign mspd = filter_en ? filt_q[SPEED_W+FILT_SHIFT-1:FILT_SHIFT] : speed_in;

    // Parameter sets, written by the configuration port
    logic [15:0] lim_mem  [N_SETS][N_FN];
    smoc_fn_t    kind_mem [N_SETS][N_FN];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < N_SETS; s++) begin
                for (int f = 0; f < N_FN; f++) begin
                    lim_mem[s][f]  <= '0;
                    kind_mem[s][f] <= FN_OFF;
                end
            end
        end else if (fn_wr.en && fn_wr.fn < 4'(N_FN)) begin
            lim_mem[fn_wr.set][fn_wr.fn]  <= fn_wr.limit;
            kind_mem[fn_wr.set][fn_wr.fn] <= fn_wr.kind;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)               act_set_q <= BASE_SET;
        else if (single_set_mode) act_set_q <= BASE_SET;
        else                      act_set_q <= pin_q[4:1];
    end

    // All nine functions of the active set evaluated in parallel
    logic [N_FN-1:0] f_on;
    logic [3:0]      rng_on;
    generate
        for (genvar f = 0; f < N_FN; f++) begin : g_fn
            always_comb begin
                unique case (kind_mem[act_set_q][f])
                    FN_ON:    f_on[f] = 1'b1;
                    FN_STILL: f_on[f] = enc_ok_q && mspd < lim_mem[act_set_q][f];
                    FN_SPEED: f_on[f] = enc_ok_q && mspd <= lim_mem[act_set_q][f];
                    default:  f_on[f] = 1'b0;
                endcase
            end
        end
        for (genvar r = 0; r < 4; r++) begin : g_rng
            assign rng_on[r] = enc_ok_q && mspd >= lim_mem[act_set_q][2*r+1]
                               && mspd <= lim_mem[act_set_q][2*r+2];
        end
    endgenerate

    function automatic logic src_cond(input logic [3:0] src, input logic [N_FN-1:0] fo,
                                      input logic [3:0] ro, input logic ok);
        if (src == 4'h0)          src_cond = 1'b0;
        else if (src <= 4'(N_FN)) src_cond = fo[src-4'h1];
        else if (src < SRC_ERR)   src_cond = ro[2'(src-SRC_RANGE0)];
        else if (src == SRC_ERR)  src_cond = ok;
        else                      src_cond = 1'b0;
    endfunction

    // Root relay: second shutdown path, latched off by a fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)         root_relay_q <= 1'b1;
        else if (pin_q[13]) root_relay_q <= 1'b0;
    end

    logic [N_OUT-1:0] on_q, dly_q, run_q, armed_q, permit_q, cond_q;
    logic [N_OUT-1:0] sync_m;
    logic             grp_off;
    generate
        for (genvar o = 0; o < N_OUT; o++) begin : g_out
            assign sync_m[o] = out_cfg[o].sync;
        end
    endgenerate
    assign grp_off = ~|(on_q & sync_m);

    generate
        for (genvar o = 0; o < N_OUT; o++) begin : g_ctl
            logic       c, rise, fall, expire;
            logic [9:0] tmr_q;
            assign c      = src_cond(out_cfg[o].src, f_on, rng_on, root_relay_q);
            assign rise   = c & ~cond_q[o];
            assign fall   = ~c & cond_q[o];
            assign expire = run_q[o] && tmr_q == '0;

            // Switch delay per output
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cond_q[o] <= 1'b0;
                    dly_q[o]  <= 1'b0;
                    run_q[o]  <= 1'b0;
                    tmr_q     <= '0;
                end else begin
                    cond_q[o] <= c;
                    if (run_q[o] && tick_q && tmr_q != '0) tmr_q <= tmr_q - 10'h001;
                    unique case (out_cfg[o].dly)
                        DL_ON_RT: begin
                            if (!c) begin
                                dly_q[o] <= 1'b0;
                                run_q[o] <= 1'b0;
                            end else if (rise) begin
                                run_q[o] <= 1'b1;
                                tmr_q    <= out_cfg[o].dly_ms;
                            end else if (expire) begin
                                dly_q[o] <= 1'b1;
                                run_q[o] <= 1'b0;
                            end
                        end
                        DL_OFFRT: begin
                            if (rise) begin
                                dly_q[o] <= 1'b1;
                                run_q[o] <= 1'b0;
                            end else if (fall) begin
                                run_q[o] <= 1'b1;
                                tmr_q    <= out_cfg[o].dly_ms;
                            end else if (expire) begin
                                dly_q[o] <= 1'b0;
                                run_q[o] <= 1'b0;
                            end
                        end
                        DL_BOTH: begin
                            if (rise || fall) begin
                                run_q[o] <= 1'b1;
                                tmr_q    <= out_cfg[o].dly_ms;
                            end else if (expire) begin
                                dly_q[o] <= c;
                                run_q[o] <= 1'b0;
                            end
                        end
                        DL_OFFNR: begin
                            if (run_q[o]) begin
                                if (expire) begin
                                    dly_q[o] <= 1'b0;
                                    run_q[o] <= 1'b0;
                                end
                            end else if (rise) begin
                                dly_q[o] <= 1'b1;
                            end else if (fall) begin
                                run_q[o] <= 1'b1;
                                tmr_q    <= out_cfg[o].dly_ms;
                            end
                        end
                        default: begin
                            dly_q[o] <= c;
                            run_q[o] <= 1'b0;
                        end
                    endcase
                end
            end

            // Start type, group permit and feedback check
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    on_q[o]     <= 1'b0;
                    armed_q[o]  <= 1'b0;
                    permit_q[o] <= 1'b1;
                end else begin
                    if (!dly_q[o] || on_q[o])
                        armed_q[o] <= 1'b0;
                    else if ((out_cfg[o].start == ST_RISE && start_rise)
                             || (out_cfg[o].start == ST_FALL && start_fall))
                        armed_q[o] <= 1'b1;
                    // Set wins: a member turning off while the group empties stays permitted
                    if (grp_off)                        permit_q[o] <= 1'b1;
                    else if (on_q[o] && !dly_q[o])      permit_q[o] <= 1'b0;
                    if (!dly_q[o])
                        on_q[o] <= 1'b0;
                    else if (!on_q[o] && pin_q[5+o]
                             && (!out_cfg[o].sync || permit_q[o])
                             && (out_cfg[o].start == ST_AUTO || armed_q[o]))
                        on_q[o] <= 1'b1;
                end
            end
        end
    endgenerate

    // Output drivers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_q <= '0;
            semi_q  <= '0;
            ext_q   <= '0;
        end else begin
            relay_q <= on_q[1:0] & {2{root_relay_q}};
            for (int i = 0; i < 4; i++) begin
                semi_q[i] <= (ana_en && i == ANA_OUT - 2) ? 1'b0
                             : on_q[i+2] ^ out_cfg[i+2].invert;
            end
            ext_q   <= on_q[7:6];
        end
    end

    // Analogue current in microamps; divide kept combinational, fmax is static
    logic [31:0] ana_prod, ana_cur;
    logic [15:0] ana_base, ana_span;
    always_comb begin
        ana_base = ana_live_zero ? ANA_LIVE_UA : 16'h0000;
        ana_span = ANA_FULL_UA - ana_base;
        ana_prod = 32'(ana_span) * 32'(mspd);
        ana_cur  = (ana_fmax == '0) ? 32'(ANA_CEIL_UA)
                   : 32'(ana_base) + ana_prod / 32'(ana_fmax);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)                       analogue_ua_q <= '0;
        else if (!ana_en)                 analogue_ua_q <= '0;
        else if (ana_cur > 32'(ANA_CEIL_UA)) analogue_ua_q <= ANA_CEIL_UA;
        else                              analogue_ua_q <= ana_cur[15:0];
    end

    AST_FILTER_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
        !filter_en |-> mspd == speed_in)
        else $error("unfiltered speed not passed through");
    AST_STARTUP_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        !enc_ok_q |-> rng_on == 4'h0 && (!f_on[0] || kind_mem[act_set_q][0] == FN_ON)
                      && (!f_on[1] || kind_mem[act_set_q][1] == FN_ON))
        else $error("speed function active during start-up delay");
    AST_ROOT_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        pin_q[13] |-> ##2 relay_q == 2'b00)
        else $error("relays not dropped after fault");
    AST_FB_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(on_q[0]) |-> $past(pin_q[5]))
        else $error("output started with feedback open");
    AST_SYNC_PERMIT: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(on_q[4]) && out_cfg[4].sync |-> $past(permit_q[4]))
        else $error("group member restarted before group off");
    AST_EDGE_START: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(on_q[2]) && out_cfg[2].start != ST_AUTO |-> $past(armed_q[2]))
        else $error("monitored start without start edge");
    AST_OFFNR_RUN: assert property (@(posedge clk) disable iff (!rst_n)
        out_cfg[6].dly == DL_OFFNR && $fell(run_q[6]) |-> !dly_q[6])
        else $error("non-retriggerable delay ended without switching off");
    AST_SINGLE_SET: assert property (@(posedge clk) disable iff (!rst_n)
        single_set_mode |=> act_set_q == BASE_SET)
        else $error("select pins used in single-set mode");
    AST_ANA_CEIL: assert property (@(posedge clk) disable iff (!rst_n)
        analogue_ua_q <= ANA_CEIL_UA and (!ana_en |=> analogue_ua_q == 16'h0000))
        else $error("analogue current beyond ceiling");
endmodule // smoc_core

// [tb/smoc_plant.sv]
// Partner model: external contactors with feedback contacts and weld sensing.
// Assumes each output drives one coil directly; one device clock.
`timescale 1ns/10ps
module smoc_plant (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] coil,
    input  wire logic [7:0] open_mask,
    input  wire logic       weld,
    output logic      [7:0] fb_closed,
    output logic            fault_in
);
    logic [7:0] drop_q;
    logic [7:0] armature_q;
    // Armature lags the coil; a welded contact stays closed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_q     <= 8'h00;
            armature_q <= 8'h00;
        end else begin
            drop_q     <= coil;
            armature_q <= drop_q | {7'h00, weld & armature_q[0]};
        end
    end
    // Loop closed only with armature released and wiring intact
    assign fb_closed = ~armature_q & ~open_mask;
    assign fault_in  = weld & armature_q[0];
endmodule // smoc_plant

// [tb/speed_monitor_output_control_test.sv]
// Self-checking bench for the speed monitor output control core.
// Assumes short tick and filter parameters; contactors come from smoc_plant.
`timescale 1ns/10ps
module speed_monitor_output_control_test;
    import smoc_pkg::*;
    logic                 clk, rst_n, filter_en, single_set_mode, start_terminal;
    logic                 fault_in, ana_en, ana_live_zero, root_relay_q, weld;
    logic [15:0]          speed_in, startup_ms, ana_fmax, analogue_ua_q;
    logic [3:0]           set_select, semi_q, act_set_q;
    logic [7:0]           fb_closed, open_mask, outs;
    logic [1:0]           relay_q, ext_q;
    smoc_filt_t           filter_sel;
    smoc_fn_wr_t          fn_wr;
    smoc_out_cfg_t [7:0]  out_cfg;
    int                   mismatches, compares;
    assign outs = {ext_q, semi_q, relay_q};

    smoc_core #(.TICK_CYC(10), .FILT_CYC_SLOW(40), .FILT_CYC_AVG(8), .FILT_CYC_FAST(2))
    u_smoc_core (.clk(clk), .rst_n(rst_n), .speed_in(speed_in), .filter_en(filter_en),
        .filter_sel(filter_sel), .startup_ms(startup_ms), .single_set_mode(single_set_mode),
        .fn_wr(fn_wr), .out_cfg(out_cfg), .start_terminal(start_terminal),
        .set_select(set_select), .fb_closed(fb_closed), .fault_in(fault_in),
        .ana_en(ana_en), .ana_live_zero(ana_live_zero), .ana_fmax(ana_fmax),
        .relay_q(relay_q), .root_relay_q(root_relay_q), .semi_q(semi_q), .ext_q(ext_q),
        .analogue_ua_q(analogue_ua_q), .act_set_q(act_set_q));
    smoc_plant u_smoc_plant (.clk(clk), .rst_n(rst_n), .coil(outs), .open_mask(open_mask),
        .weld(weld), .fb_closed(fb_closed), .fault_in(fault_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic summarize();
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Sample at the falling edge so clocked updates have landed
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_out(input int i, input logic v, input int lim);
        int k;
        k = 0;
        while (outs[i] !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
        chk({15'h0, outs[i]}, {15'h0, v});
        if (outs[i] !== v) summarize();
    endtask
    task automatic wr_fn(input logic [3:0] fn, input smoc_fn_t k, input logic [15:0] lim);
        @(posedge clk);
        fn_wr <= '{en: 1'b1, kind: k, set: BASE_SET, fn: fn, limit: lim};
        @(posedge clk);
        fn_wr.en <= 1'b0;
    endtask
    task automatic cfg(input int i, input logic [3:0] src, input smoc_start_t st,
                       input smoc_dly_t d, input logic [9:0] ms, input logic inv);
        @(posedge clk);
        out_cfg[i] <= '{src: src, start: st, dly: d, dly_ms: ms, sync: 1'b0, invert: inv};
    endtask
    task automatic drv_speed(input logic [15:0] v);
        @(posedge clk);
        speed_in <= v;
    endtask

    task automatic t_startup();
        wr_fn(4'h0, FN_STILL, 16'h0064);
        cfg(0, 4'h1, ST_AUTO, DL_NONE, 10'h000, 1'b0);
        tick(6);
        chk({15'h0, relay_q[0]}, 16'h0000);
        chk({12'h0, act_set_q}, {12'h0, BASE_SET});
        wait_out(0, 1'b1, 60);
    endtask
    task automatic t_start();
        cfg(2, 4'h1, ST_RISE, DL_NONE, 10'h000, 1'b0);
        cfg(5, 4'h0, ST_AUTO, DL_NONE, 10'h000, 1'b1);
        tick(12);
        chk({15'h0, semi_q[0]}, 16'h0000);
        chk({15'h0, semi_q[3]}, 16'h0001);
        @(posedge clk);
        start_terminal <= 1'b1;
        wait_out(2, 1'b1, 12);
        cfg(3, 4'h1, ST_FALL, DL_NONE, 10'h000, 1'b0);
        tick(12);
        chk({15'h0, semi_q[1]}, 16'h0000);
        @(posedge clk);
        start_terminal <= 1'b0;
        wait_out(3, 1'b1, 12);
    endtask
    task automatic t_sync();
        wr_fn(4'h2, FN_SPEED, 16'h0032);
        cfg(4, 4'h3, ST_AUTO, DL_NONE, 10'h000, 1'b0);
        cfg(7, 4'h1, ST_AUTO, DL_NONE, 10'h000, 1'b0);
        @(posedge clk);
        out_cfg[4].sync <= 1'b1;
        out_cfg[7].sync <= 1'b1;
        wait_out(4, 1'b1, 12);
        wait_out(7, 1'b1, 12);
        drv_speed(16'h003c);
        wait_out(4, 1'b0, 12);
        drv_speed(16'h000a);
        tick(12);
        chk({15'h0, semi_q[2]}, 16'h0000);
        @(posedge clk);
        out_cfg[7].src <= 4'h0;
        wait_out(4, 1'b1, 12);
        @(posedge clk);
        out_cfg[7].src <= 4'h1;
        wait_out(7, 1'b1, 16);
    endtask
    task automatic t_feedback();
        @(posedge clk);
        open_mask <= 8'h02;
        // Let the open loop pass the pin synchroniser first
        tick(6);
        cfg(1, 4'h1, ST_AUTO, DL_NONE, 10'h000, 1'b0);
        tick(15);
        chk({15'h0, relay_q[1]}, 16'h0000);
        chk({15'h0, relay_q[0]}, 16'h0001);
    endtask
    task automatic t_delay();
        wr_fn(4'h1, FN_SPEED, 16'h0032);
        cfg(6, 4'h2, ST_AUTO, DL_OFFRT, 10'h003, 1'b0);
        wait_out(6, 1'b1, 12);
        drv_speed(16'h003c);
        tick(15);
        chk({15'h0, ext_q[0]}, 16'h0001);
        drv_speed(16'h000a);
        tick(50);
        chk({15'h0, ext_q[0]}, 16'h0001);
        drv_speed(16'h003c);
        tick(25);
        chk({15'h0, ext_q[0]}, 16'h0001);
        wait_out(6, 1'b0, 30);
        drv_speed(16'h000a);
        cfg(6, 4'h2, ST_AUTO, DL_OFFNR, 10'h003, 1'b0);
        wait_out(6, 1'b1, 12);
        drv_speed(16'h003c);
        tick(12);
        drv_speed(16'h000a);
        wait_out(6, 1'b0, 40);
        cfg(6, 4'h2, ST_AUTO, DL_ON_RT, 10'h003, 1'b0);
        drv_speed(16'h003c);
        drv_speed(16'h000a);
        tick(15);
        chk({15'h0, ext_q[0]}, 16'h0000);
        wait_out(6, 1'b1, 40);
        cfg(6, 4'h2, ST_AUTO, DL_BOTH, 10'h003, 1'b0);
        drv_speed(16'h003c);
        tick(15);
        chk({15'h0, ext_q[0]}, 16'h0001);
        drv_speed(16'h000a);
        drv_speed(16'h003c);
        tick(15);
        chk({15'h0, ext_q[0]}, 16'h0001);
        wait_out(6, 1'b0, 40);
    endtask
    task automatic t_fault();
        tick(6);
        @(posedge clk);
        weld <= 1'b1;
        tick(10);
        chk({13'h0, root_relay_q, relay_q}, 16'h0000);
    endtask
    task automatic t_analogue();
        @(posedge clk);
        ana_en        <= 1'b1;
        ana_live_zero <= 1'b1;
        ana_fmax      <= 16'h03e8;
        speed_in      <= 16'h01f4;
        tick(8);
        chk(analogue_ua_q, 16'h2ee0);
        chk({15'h0, semi_q[3]}, 16'h0000);
        drv_speed(16'h07d0);
        tick(8);
        chk(analogue_ua_q, ANA_CEIL_UA);
        @(posedge clk);
        ana_live_zero <= 1'b0;
        speed_in      <= 16'h01f4;
        tick(8);
        chk(analogue_ua_q, 16'h2710);
        drv_speed(16'h041a);
        tick(8);
        chk(analogue_ua_q, 16'h5208);
        drv_speed(16'h01f4);
        tick(300);
        @(posedge clk);
        filter_en <= 1'b1;
        speed_in  <= 16'h03e8;
        tick(8);
        chk({15'h0, analogue_ua_q < 16'h4e20}, 16'h0001);
        tick(300);
        chk(analogue_ua_q, 16'h4e20);
        @(posedge clk);
        single_set_mode <= 1'b0;
        tick(6);
        chk({12'h0, act_set_q}, 16'h0005);
    endtask

    initial begin
        mismatches = 0;
        compares = 0;
        rst_n = 1'b0;
        speed_in = 16'h000a;
        filter_en = 1'b0;
        filter_sel = FS_FAST;
        startup_ms = 16'h0002;
        single_set_mode = 1'b1;
        set_select = 4'h5;
        fn_wr = '0;
        out_cfg = '0;
        start_terminal = 1'b0;
        ana_en = 1'b0;
        ana_live_zero = 1'b0;
        ana_fmax = 16'h0000;
        open_mask = 8'h00;
        weld = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_startup();
        t_start();
        t_sync();
        t_feedback();
        t_delay();
        t_fault();
        t_analogue();
        summarize();
    end
endmodule // speed_monitor_output_control_test
